// file: core/adc_port_pkg.sv
package adc_port_pkg;
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned DATA_W           = 16;
    // acquisition, conversion and wake times in ns
    localparam int unsigned ACQ_NS           = 400;
    localparam int unsigned CONV_NS          = 1450;
    localparam int unsigned THRU_MAX_NS      = 2000;
    localparam int unsigned WAKE_NS          = 400;
    localparam int unsigned START_HI_NS      = 250;
    localparam int unsigned STROBE_MIN_NS    = 40;
    localparam int unsigned ACQ_CYC          = (ACQ_NS * CLK_MHZ) / 1000;
    localparam int unsigned CONV_CYC         = (CONV_NS * CLK_MHZ) / 1000;
    localparam int unsigned THRU_MAX_CYC     = (THRU_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned WAKE_CYC         = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned START_HI_CYC     = (START_HI_NS * CLK_MHZ) / 1000;
    localparam int unsigned STROBE_CYC       = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W            = 12;
endpackage

// file: core/adc_port_if.sv
`timescale 1ns/1ns
interface adc_port_if;
    logic                          sel_n;
    logic                          start_conv_n;
    logic                          rd_n;
    logic                          power_down_n;
    logic                          busy_n;
    logic [adc_port_pkg::DATA_W-1:0] result_bus;
    logic                          result_oe;

    modport dev (input sel_n, start_conv_n, rd_n, power_down_n, output busy_n, result_bus, result_oe);
    modport host (output sel_n, start_conv_n, rd_n, power_down_n, input busy_n, result_bus, result_oe);
endinterface

// file: core/adc_port_dev.sv
`timescale 1ns/1ns
// Contract
// - start on start falling edge while selected
// - strobes ignored while select high
// - busy low during conversion
// - result valid by busy rising edge
// - drivers on only when read and select low
// - read before select waits for select
// - sixteen-bit word, top line is msb
// - power down with select low: nap
// - power down with select high: sleep
// - host waits wake time before start
// - host raises start early or after busy
// - acquisition plus conversion within 2 us
// - acquisition phase at most 400 ns
// - host may read 5 ns before busy rises
// - starts ignored while converting
// - result in two's complement
module adc_port_dev (
    input  wire logic                            ref_clk_i,
    input  wire logic                            rst_i,
    adc_port_if.dev                              port,
    input  wire logic [adc_port_pkg::DATA_W-1:0] sample_i,
    output logic                                 nap_o,
    output logic                                 sleep_o,
    output logic                                 done_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACQ  = 3'b010,
        ST_CONV = 3'b100
    } dev_state_t;

    dev_state_t                        state_q;
    logic [adc_port_pkg::CNT_W-1:0]    cnt_q;
    // host pins are asynchronous to ref_clk, two flops each
    logic [1:0]                        sel_s_q;
    logic [1:0]                        st_s_q;
    logic [1:0]                        rd_s_q;
    logic [1:0]                        pd_s_q;
    logic                              st_prev_q;
    logic [adc_port_pkg::DATA_W-1:0]   result_q;
    logic                              busy_n_q;
    logic                              oe_q;
    logic                              nap_q;
    logic                              sleep_q;
    logic                              done_q;
    logic                              sel_l;
    logic                              st_l;
    logic                              rd_l;
    logic                              pd_l;
    logic                              start_fall;
    logic                              start_go;
    logic                              conv_last;
    logic                              acq_last;

    // true on the final cycle of a phase that lasts len cycles
    function automatic logic last_cycle(input logic [adc_port_pkg::CNT_W-1:0] cnt,
                                        input int unsigned                   len);
        return cnt == adc_port_pkg::CNT_W'(len - 1);
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sel_s_q <= 2'h3;
        end else begin
            sel_s_q <= {sel_s_q[0], port.sel_n};
        end
    end

    // start strobe also feeds the edge detector below
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_s_q <= 2'h3;
        end else begin
            st_s_q <= {st_s_q[0], port.start_conv_n};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_s_q <= 2'h3;
        end else begin
            rd_s_q <= {rd_s_q[0], port.rd_n};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pd_s_q <= 2'h3;
        end else begin
            pd_s_q <= {pd_s_q[0], port.power_down_n};
        end
    end

    assign sel_l = sel_s_q[1];
    assign st_l  = st_s_q[1];
    assign rd_l  = rd_s_q[1];
    assign pd_l  = pd_s_q[1];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_prev_q <= 1'b1;
        end else begin
            st_prev_q <= st_l;
        end
    end

    // edge only counts while selected and awake
    assign start_fall = st_prev_q & ~st_l & ~sel_l & pd_l;
    // edges during conversion or acquisition are dropped, never queued
    assign start_go   = start_fall && state_q == ST_IDLE;

    // phase ends for the state machine; conv_last also drives busy and the latch
    assign conv_last  = state_q == ST_CONV && last_cycle(cnt_q, adc_port_pkg::CONV_CYC);
    assign acq_last   = state_q == ST_ACQ && last_cycle(cnt_q, adc_port_pkg::ACQ_CYC);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_go) begin
                        state_q <= ST_CONV;
                        cnt_q   <= '0;
                    end
                end
                ST_CONV: begin
                    // further starts ignored here
                    if (conv_last) begin
                        state_q <= ST_ACQ;
                        cnt_q   <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_ACQ: begin
                    // track phase before next sample can be taken
                    if (acq_last) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_n_q <= 1'b1;
        end else begin
            // drops on the edge that leaves idle, rises on the edge that latches the word
            busy_n_q <= ~(start_go | (state_q == ST_CONV && !conv_last));
        end
    end

    // capture in the cycle busy rises, so word is stable at that edge
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            result_q <= '0;
        end else if (conv_last) begin
            result_q <= sample_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= conv_last;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            oe_q <= 1'b0;
        end else begin
            // drivers follow the strobes three edges late
            oe_q <= ~rd_l & ~sel_l;
        end
    end

    // power-down low with select low keeps logic and reference alive
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            nap_q <= 1'b0;
        end else begin
            nap_q <= ~pd_l & ~sel_l;
        end
    end

    // power-down low with select high shuts all bias off
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= ~pd_l & sel_l;
        end
    end

    assign port.busy_n     = busy_n_q;
    assign port.result_bus = result_q;
    assign port.result_oe  = oe_q;
    assign nap_o           = nap_q;
    assign sleep_o         = sleep_q;
    assign done_o          = done_q;
endmodule // adc_port_dev

// file: core/adc_port_host.sv
`timescale 1ns/1ns
module adc_port_host (
    input  wire logic                            ref_clk_i,
    input  wire logic                            rst_i,
    adc_port_if.host                             port,
    input  wire logic                            conv_req_i,
    input  wire logic                            read_req_i,
    input  wire logic                            shutdown_i,
    input  wire logic                            sleep_sel_i,
    output logic                                 ready_o,
    output logic                                 data_valid_o,
    output logic [adc_port_pkg::DATA_W-1:0]      data_o
);
    typedef enum logic [4:0] {
        H_WAKE = 5'b00001,
        H_IDLE = 5'b00010,
        H_CONV = 5'b00100,
        H_READ = 5'b01000,
        H_DOWN = 5'b10000
    } host_state_t;

    host_state_t                     state_q;
    logic [adc_port_pkg::CNT_W-1:0]  cnt_q;
    logic [1:0]                      busy_s_q;
    logic                            sel_n_q, st_n_q, rd_n_q, pd_n_q;
    logic                            valid_q;
    logic [adc_port_pkg::DATA_W-1:0] data_q;
    logic [adc_port_pkg::DATA_W-1:0] bus_s1_q, bus_s2_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            busy_s_q <= 2'h3;
            bus_s1_q <= '0;
            bus_s2_q <= '0;
        end else begin
            busy_s_q <= {busy_s_q[0], port.busy_n};
            bus_s1_q <= port.result_bus;
            bus_s2_q <= bus_s1_q;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= H_WAKE;
            cnt_q   <= '0;
            sel_n_q <= 1'b0;
            st_n_q  <= 1'b1;
            rd_n_q  <= 1'b1;
            pd_n_q  <= 1'b1;
            valid_q <= 1'b0;
            data_q  <= '0;
        end else begin
            valid_q <= 1'b0;
            case (state_q)
                H_WAKE: begin
                    sel_n_q <= 1'b0;
                    pd_n_q  <= 1'b1;
                    if (cnt_q == adc_port_pkg::CNT_W'(adc_port_pkg::WAKE_CYC)) begin
                        state_q <= H_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                H_IDLE: begin
                    cnt_q <= '0;
                    if (shutdown_i) begin
                        sel_n_q <= sleep_sel_i;
                        state_q <= H_DOWN;
                    end else if (conv_req_i) begin
                        st_n_q  <= 1'b0;
                        state_q <= H_CONV;
                    end else if (read_req_i) begin
                        rd_n_q  <= 1'b0;
                        state_q <= H_READ;
                    end
                end
                H_CONV: begin
                    cnt_q <= cnt_q + 1'b1;
                    // short low pulse, well inside the quiet window
                    if (cnt_q == adc_port_pkg::CNT_W'(adc_port_pkg::STROBE_CYC + 3)) begin
                        st_n_q <= 1'b1;
                    end
                    // full throughput window before next start
                    if (cnt_q == adc_port_pkg::CNT_W'(adc_port_pkg::THRU_MAX_CYC + 8)) begin
                        rd_n_q  <= 1'b0;
                        cnt_q   <= '0;
                        state_q <= H_READ;
                    end
                end
                H_READ: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == adc_port_pkg::CNT_W'(adc_port_pkg::STROBE_CYC + 4)) begin
                        data_q  <= bus_s2_q;
                        valid_q <= 1'b1;
                        rd_n_q  <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                H_DOWN: begin
                    pd_n_q <= 1'b0;
                    if (!shutdown_i) begin
                        pd_n_q  <= 1'b1;
                        sel_n_q <= 1'b0;
                        cnt_q   <= '0;
                        state_q <= H_WAKE;
                    end
                end
                default: begin
                    state_q <= H_WAKE;
                end
            endcase
        end
    end

    assign port.sel_n        = sel_n_q;
    assign port.start_conv_n = st_n_q;
    assign port.rd_n         = rd_n_q;
    assign port.power_down_n = pd_n_q;
    assign ready_o           = (state_q == H_IDLE) && busy_s_q[1];
    assign data_valid_o      = valid_q;
    assign data_o            = data_q;
endmodule // adc_port_host

// file: verification/adc_port_monitor.sv
`timescale 1ns/1ns
module adc_port_monitor (
    input wire logic                            ref_clk_i,
    input wire logic                            rst_i,
    input wire logic                            sel_n,
    input wire logic                            start_conv_n,
    input wire logic                            rd_n,
    input wire logic                            power_down_n,
    input wire logic                            busy_n,
    input wire logic [adc_port_pkg::DATA_W-1:0] result_bus,
    input wire logic                            result_oe
);
    logic [8:0] low_q;
    logic [7:0] idle_q;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    // length of the current busy-low stretch
    always_ff @(posedge ref_clk_i) begin
        low_q <= (rst_i || busy_n) ? 9'h000 : low_q + 9'h001;
    end
    // idle cycles since busy rose, saturating
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) idle_q <= 8'hff;
        else if (!busy_n) idle_q <= 8'h00;
        else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
    end
    property p_start;
        $fell(start_conv_n) && !sel_n && power_down_n && busy_n && idle_q > 8'h6e ##1
            (!sel_n && power_down_n)[*2] |-> ##[1:3] !busy_n;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_sel_block;
        sel_n[*6] ##0 busy_n |=> busy_n;
    endproperty
    a_sel_block: assert property (p_sel_block) else $error("busy fell while deselected");
    property p_busy_len;
        $rose(busy_n) |-> low_q == 9'(adc_port_pkg::CONV_CYC) &&
            low_q + 9'(adc_port_pkg::ACQ_CYC) <= 9'(adc_port_pkg::THRU_MAX_CYC);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("wrong busy length");
    property p_hold;
        !busy_n |-> $stable(result_bus);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed during conversion");
    property p_oe_on;
        (!rd_n && !sel_n)[*4] |-> result_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("drivers not enabled");
    property p_oe_off;
        (rd_n || sel_n)[*4] |-> !result_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("drivers enabled");
    property p_acq_gap;
        $fell(busy_n) |-> idle_q >= 8'h63;
    endproperty
    a_acq_gap: assert property (p_acq_gap) else $error("start in acquisition");
    property p_fall_cause;
        $fell(busy_n) |-> !$past(start_conv_n, 3) && !$past(sel_n, 3);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("busy fell without start");
    c_conv: cover property ($rose(busy_n));
    c_read: cover property ($rose(result_oe));
    c_sleep: cover property (sel_n && !power_down_n);
endmodule // adc_port_monitor

// file: verification/tb.sv
`timescale 1ns/1ns
module tb;
    localparam int W = adc_port_pkg::DATA_W;
    typedef struct packed {logic rd_only; logic [W-1:0] sample; logic [W-1:0] exp;} row_t;
    logic         ref_clk, rst, conv_req, read_req, shutdown, sleep_sel, ready, dv, nap, sleep, nap_b, sleep_b, done_b;
    logic [W-1:0] data, sample, sample_b;
    int           bad_count, checked, n;
    row_t         rows [4] = '{'{1'b0, 16'h7fff, 16'h7fff}, '{1'b0, 16'h8000, 16'h8000},
                               '{1'b1, 16'h0001, 16'h8000}, '{1'b0, 16'ha5c3, 16'ha5c3}};
    adc_port_if bus ();
    adc_port_if bus_b ();
    adc_port_host i_adc_port_host (.ref_clk_i(ref_clk), .rst_i(rst), .port(bus), .conv_req_i(conv_req),
        .read_req_i(read_req), .shutdown_i(shutdown), .sleep_sel_i(sleep_sel), .ready_o(ready), .data_valid_o(dv),
        .data_o(data));
    adc_port_dev i_adc_port_dev (.ref_clk_i(ref_clk), .rst_i(rst), .port(bus), .sample_i(sample), .nap_o(nap),
        .sleep_o(sleep), .done_o());
    adc_port_dev i_adc_port_dev_b (.ref_clk_i(ref_clk), .rst_i(rst), .port(bus_b), .sample_i(sample_b),
        .nap_o(nap_b), .sleep_o(sleep_b), .done_o(done_b));
    adc_port_monitor i_adc_port_monitor (.ref_clk_i(ref_clk), .rst_i(rst), .sel_n(bus.sel_n),
        .start_conv_n(bus.start_conv_n), .rd_n(bus.rd_n), .power_down_n(bus.power_down_n), .busy_n(bus.busy_n),
        .result_bus(bus.result_bus), .result_oe(bus.result_oe));
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk_word(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {{(W-1){1'b0}}, exp}, {{(W-1){1'b0}}, got});
    endtask
    function automatic logic pick(input int sel);
        return (sel == 0) ? ready : (sel == 1) ? dv : bus_b.busy_n;
    endfunction
    task automatic wait_hi(input int sel);
        n = 0;
        while (pick(sel) !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
        if (pick(sel) !== 1'b1) begin
            bad_count++;
            $display("BAD wait %0d expected 1 seen %b", sel, pick(sel));
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // three conversions, one plain read and the hand tests come to about 2200 cycles
    initial begin
        repeat (8000) @(posedge ref_clk);
        bad_count++;
        $display("watchdog expired");
        wrap_up();
    end
    initial begin
        {rst, conv_req, read_req, shutdown, sleep_sel} = 5'h10;
        sample = '0;
        sample_b = 16'h5a3c;
        {bus_b.sel_n, bus_b.start_conv_n, bus_b.rd_n, bus_b.power_down_n} = 4'hf;
        tick(10);
        rst = 1'b0;
        foreach (rows[i]) begin
            sample = rows[i].sample;
            wait_hi(0);
            conv_req = !rows[i].rd_only;
            read_req = rows[i].rd_only;
            tick(1);
            {conv_req, read_req} = 2'h0;
            wait_hi(1);
            chk_bit("valid", 1'b1, dv);
            chk_bit("oe reading", 1'b1, bus.result_oe);
            chk_word("data", rows[i].exp, data);
            chk_word("bus", rows[i].exp, bus.result_bus);
            tick(20);
            chk_bit("oe idle", 1'b0, bus.result_oe);
            $display("row %0d done", i);
        end
        {bus_b.start_conv_n, bus_b.rd_n} = 2'h0;
        tick(10);
        chk_bit("busy deselected", 1'b1, bus_b.busy_n);
        chk_bit("oe deselected", 1'b0, bus_b.result_oe);
        bus_b.sel_n = 1'b0;
        tick(1);
        chk_bit("oe gated", 1'b0, bus_b.result_oe);
        tick(5);
        chk_bit("oe on", 1'b1, bus_b.result_oe);
        {bus_b.start_conv_n, bus_b.rd_n} = 2'h3;
        tick(5);
        bus_b.start_conv_n = 1'b0;
        tick(6);
        chk_bit("busy low", 1'b0, bus_b.busy_n);
        chk_word("old result", 16'h0000, bus_b.result_bus);
        bus_b.start_conv_n = 1'b1;
        tick(20);
        bus_b.start_conv_n = 1'b0;
        wait_hi(2);
        chk_word("conv time", 16'(3 + adc_port_pkg::CONV_CYC), 16'(n + 26));
        chk_word("new result", sample_b, bus_b.result_bus);
        chk_bit("done pulse", 1'b1, done_b);
        bus_b.start_conv_n = 1'b1;
        tick(2);
        bus_b.start_conv_n = 1'b0;
        tick(3);
        chk_bit("acq start", 1'b1, bus_b.busy_n);
        tick(7);
        bus_b.power_down_n = 1'b0;
        tick(6);
        chk_bit("nap", 1'b1, nap_b);
        $display("direct device tests done");
        {shutdown, sleep_sel} = 2'h3;
        tick(10);
        chk_bit("sleep", 1'b1, sleep);
        chk_bit("no nap", 1'b0, nap);
        $display("power tests done");
        rst = 1'b1;
        tick(2);
        chk_bit("busy reset", 1'b1, bus_b.busy_n);
        chk_bit("oe reset", 1'b0, bus_b.result_oe);
        chk_word("result reset", 16'h0000, bus_b.result_bus);
        chk_bit("nap reset", 1'b0, nap_b);
        $display("reset test done");
        wrap_up();
    end
endmodule // tb
